// ---- pkg/adc_seq_pkg.sv ----
package adc_seq_pkg;

   // ****************************************************************
   // timing of the conversion cycle
   // ****************************************************************
   localparam int          CLK_PERIOD_NS    = 25;
   localparam int          CNT_WIDTH        = 4;
   localparam int          RESULT_BITS      = 10;
   localparam logic [3:0]  CNT_RESET        = 4'h0;
   localparam logic [3:0]  CNT_FIRST        = 4'h1;
   localparam logic [3:0]  CNT_CALIB_LAST   = 4'h2;
   localparam logic [3:0]  CNT_SAMPLE       = 4'h3;
   localparam logic [3:0]  CNT_FIRST_BIT    = 4'h4;
   localparam logic [3:0]  CNT_LAST_BIT     = 4'hd;
   localparam logic [3:0]  CNT_REF_FREEZE   = 4'hd;
   localparam logic [3:0]  CNT_LAST         = 4'he;

   // ****************************************************************
   // values after reset
   // ****************************************************************
   localparam logic        DATA_RESET       = 1'b0;
   localparam logic        OE_N_RESET       = 1'b1;
   localparam logic        SYNC_RESET       = 1'b1;
   localparam logic        TRACK_RESET      = 1'b1;
   localparam logic        REFOK_RESET      = 1'b1;
   localparam logic [9:0]  CODE_RESET       = 10'h000;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_CONVERT
   } seq_state_type;

   typedef enum logic [1:0] {
      MODE_NONE,
      MODE_SINGLE_SHOT,
      MODE_SYNCHRONIZED,
      MODE_FREE_RUN
   } run_mode_type;

endpackage

// ---- logic/sar_register.sv ----
// ****************************************************************
// successive approximation register
// ****************************************************************
module sar_register #(
   parameter int WIDTH = 10
) (
   input  wire logic             clk_sys,
   input  wire logic             arst_n,
   input  wire logic             init,
   input  wire logic             step,
   input  wire logic             comp_high,
   output logic [WIDTH-1:0]      trial_code,
   output logic [WIDTH-1:0]      result_code
);

   logic [WIDTH-1:0] code_q;
   logic [WIDTH-1:0] code_d;
   logic [WIDTH-1:0] probe_q;
   logic [WIDTH-1:0] result_q;

   // one-hot pointer to the bit under test, msb first
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         probe_q <= '0;
      end else if (init) begin
         probe_q <= {1'b1, {(WIDTH-1){1'b0}}};
      end else if (step) begin
         probe_q <= probe_q >> 1;
      end
   end

   // keep or drop the tested bit; straight binary, zero at bottom
   generate
      for (genvar i = 0; i < WIDTH; i++) begin : g_bit
         always_comb begin
            if (probe_q[i]) begin
               code_d[i] = comp_high;
            end else begin
               code_d[i] = code_q[i];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         code_q <= '0;
      end else if (init) begin
         code_q <= '0;
      end else if (step) begin
         code_q <= code_d;
      end
   end

   // finished code latched when the last bit is tested
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         result_q <= '0;
      end else if (step && probe_q[0]) begin
         result_q <= code_d;
      end
   end

   assign trial_code  = code_q | probe_q;
   assign result_code = result_q;

endmodule // sar_register

// ---- logic/serial_adc_conversion_sequencer.sv ----
// ****************************************************************
// conversion sequencer of a serial successive approximation converter
// ****************************************************************
module serial_adc_conversion_sequencer #(
   parameter int RESULT_WIDTH = 10
) (
   input  wire logic                     clk_sys,
   input  wire logic                     arst_n,
   input  wire logic                     conversion_request_n,
   input  wire logic                     comp_high,
   output logic                          serial_data,
   output logic                          serial_data_oe_n,
   output logic                          track_enable,
   output logic                          calib_active,
   output logic                          ref_change_ok,
   output logic [RESULT_WIDTH-1:0]       dac_code,
   output logic [RESULT_WIDTH-1:0]       result_code,
   output logic                          result_valid,
   output logic                          conv_start,
   output logic                          conv_busy,
   output logic [3:0]                    conv_clock,
   output adc_seq_pkg::run_mode_type     run_mode
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   adc_seq_pkg::seq_state_type state_q;
   adc_seq_pkg::seq_state_type state_d;
   adc_seq_pkg::run_mode_type  mode_q;
   logic [3:0]                 cnt_q;
   logic [3:0]                 cnt_d;
   logic                       req_meta_q;
   logic                       req_sync_q;
   logic                       req_low;
   logic                       start_now;
   logic                       last_clock;
   logic                       chain_next;
   logic                       released_q;
   logic                       from_idle_q;
   logic                       data_q;
   logic                       oe_n_q;
   logic                       track_q;
   logic                       refok_q;
   logic                       start_q;
   logic                       valid_q;
   logic                       sar_init;
   logic                       sar_step;
   logic [RESULT_WIDTH-1:0]    trial_code;
   logic [RESULT_WIDTH-1:0]    sar_result;

   // ****************************************************************
   // helpers
   // ****************************************************************

   // true when the counter sits inside an inclusive span of clocks
   function automatic logic in_span(input logic [3:0] cnt,
                                    input logic [3:0] lo,
                                    input logic [3:0] hi);
      in_span = (cnt >= lo) && (cnt <= hi);
   endfunction

   // ****************************************************************
   // request input
   // ****************************************************************

   // request pin comes from another domain, so two flops first;
   // this costs two clocks of start latency, a fixed and known offset
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         req_meta_q <= adc_seq_pkg::SYNC_RESET;
         req_sync_q <= adc_seq_pkg::SYNC_RESET;
      end else begin
         req_meta_q <= conversion_request_n;
         req_sync_q <= req_meta_q;
      end
   end

   assign req_low = ~req_sync_q;

   // ****************************************************************
   // sequence decisions
   // ****************************************************************

   // idle with request low begins conversion clock one next edge
   assign start_now  = (state_q == adc_seq_pkg::SEQ_IDLE) && req_low;
   assign last_clock = (state_q == adc_seq_pkg::SEQ_CONVERT) &&
                       (cnt_q == adc_seq_pkg::CNT_LAST);
   // request still low at clock fourteen chains the next cycle
   assign chain_next = last_clock && req_low;

   // next state: mode depends only on how the request line is used
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         adc_seq_pkg::SEQ_IDLE: begin
            if (start_now) begin
               state_d = adc_seq_pkg::SEQ_CONVERT;
            end
         end
         adc_seq_pkg::SEQ_CONVERT: begin
            if (last_clock && !req_low) begin
               state_d = adc_seq_pkg::SEQ_IDLE;
            end
         end
         default: begin
            state_d = adc_seq_pkg::SEQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= adc_seq_pkg::SEQ_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // ****************************************************************
   // conversion clock counter, one to fourteen
   // ****************************************************************

   // counter restarts at one on a start or a chained cycle
   always_comb begin
      if (start_now || chain_next) begin
         cnt_d = adc_seq_pkg::CNT_FIRST;
      end else if (last_clock) begin
         cnt_d = adc_seq_pkg::CNT_RESET;
      end else if (state_q == adc_seq_pkg::SEQ_CONVERT) begin
         cnt_d = cnt_q + 4'h1;
      end else begin
         cnt_d = adc_seq_pkg::CNT_RESET;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= adc_seq_pkg::CNT_RESET;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // ****************************************************************
   // track and hold, calibration and reference window
   // ****************************************************************

   // tracking from clock fourteen until the end of clock three
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         track_q <= adc_seq_pkg::TRACK_RESET;
      end else if (state_q == adc_seq_pkg::SEQ_CONVERT &&
                   cnt_q == adc_seq_pkg::CNT_SAMPLE) begin
         track_q <= 1'b0;
      end else if (state_q == adc_seq_pkg::SEQ_CONVERT &&
                   cnt_q == adc_seq_pkg::CNT_LAST_BIT) begin
         track_q <= 1'b1;
      end
   end

   // references may move from end of clock thirteen to end of three;
   // only advisory, the host owns the ladder itself
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         refok_q <= adc_seq_pkg::REFOK_RESET;
      end else if (state_q == adc_seq_pkg::SEQ_CONVERT &&
                   cnt_q == adc_seq_pkg::CNT_SAMPLE) begin
         refok_q <= 1'b0;
      end else if (state_q == adc_seq_pkg::SEQ_CONVERT &&
                   cnt_q == adc_seq_pkg::CNT_REF_FREEZE) begin
         refok_q <= 1'b1;
      end
   end

   // offset calibration runs during clocks one and two
   assign calib_active = (state_q == adc_seq_pkg::SEQ_CONVERT) &&
                         in_span(cnt_q, adc_seq_pkg::CNT_FIRST, adc_seq_pkg::CNT_CALIB_LAST);

   // ****************************************************************
   // approximation engine
   // ****************************************************************

   // init as the sample is frozen, then one trial per clock
   assign sar_init = (state_q == adc_seq_pkg::SEQ_CONVERT) &&
                     (cnt_q == adc_seq_pkg::CNT_SAMPLE);
   assign sar_step = (state_q == adc_seq_pkg::SEQ_CONVERT) &&
                     in_span(cnt_q, adc_seq_pkg::CNT_FIRST_BIT, adc_seq_pkg::CNT_LAST_BIT);

   sar_register #(
      .WIDTH       (RESULT_WIDTH)
   ) u_sar (
      .clk_sys     (clk_sys),
      .arst_n      (arst_n),
      .init        (sar_init),
      .step        (sar_step),
      .comp_high   (comp_high),
      .trial_code  (trial_code),
      .result_code (sar_result)
   );

   // ****************************************************************
   // serial data output
   // ****************************************************************

   // each bit decided at the end of clocks four..thirteen is shown the
   // next clock, so the lsb stands only during clock fourteen
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         data_q <= adc_seq_pkg::DATA_RESET;
      end else if (sar_step) begin
         data_q <= comp_high;
      end else begin
         data_q <= 1'b0;
      end
   end

   // driver on from the start, off only if released at clock fourteen;
   // a chained cycle keeps it on, so free run never floats
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         oe_n_q <= adc_seq_pkg::OE_N_RESET;
      end else if (start_now) begin
         oe_n_q <= 1'b0;
      end else if (last_clock && !req_low) begin
         oe_n_q <= 1'b1;
      end
   end

   // ****************************************************************
   // observed mode of use
   // ****************************************************************

   // sticky: request seen high during the running cycle
   // set wins over the clear when both fall in one clock
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         released_q <= 1'b0;
      end else if (state_q == adc_seq_pkg::SEQ_CONVERT && !req_low) begin
         released_q <= 1'b1;
      end else if (start_now || chain_next) begin
         released_q <= 1'b0;
      end
   end

   // remembers whether the running cycle began from idle
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         from_idle_q <= 1'b0;
      end else if (start_now) begin
         from_idle_q <= 1'b1;
      end else if (chain_next) begin
         from_idle_q <= 1'b0;
      end
   end

   // classify at clock fourteen and again at a start from idle after a single shot that began from idle; nothing here steers the sequence
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         mode_q <= adc_seq_pkg::MODE_NONE;
      end else if (last_clock) begin
         if (!req_low) begin
            mode_q <= adc_seq_pkg::MODE_SINGLE_SHOT;
         end else if (released_q) begin
            mode_q <= adc_seq_pkg::MODE_SYNCHRONIZED;
         end else begin
            mode_q <= adc_seq_pkg::MODE_FREE_RUN;
         end
      end else if (start_now && mode_q == adc_seq_pkg::MODE_SINGLE_SHOT && from_idle_q) begin
         mode_q <= adc_seq_pkg::MODE_SYNCHRONIZED;
      end
   end

   // ****************************************************************
   // status pulses
   // ****************************************************************

   // start pulse marks conversion clock one, valid marks fresh result
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         start_q <= 1'b0;
         valid_q <= 1'b0;
      end else begin
         start_q <= start_now || chain_next;
         valid_q <= sar_step && (cnt_q == adc_seq_pkg::CNT_LAST_BIT);
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign serial_data      = data_q;
   assign serial_data_oe_n = oe_n_q;
   assign track_enable     = track_q;
   assign ref_change_ok    = refok_q;
   assign dac_code         = trial_code;
   assign result_code      = sar_result;
   assign result_valid     = valid_q;
   assign conv_start       = start_q;
   assign conv_busy        = (state_q == adc_seq_pkg::SEQ_CONVERT);
   assign conv_clock       = cnt_q;
   assign run_mode         = mode_q;

endmodule // serial_adc_conversion_sequencer

// ---- verification/adc_seq_properties.sv ----
// ****************************************************************
// timing checks seen at the sequencer ports
// ****************************************************************
module adc_seq_checker #(
   parameter int RESULT_WIDTH = 10
) (
   input wire logic                      clk_sys,
   input wire logic                      arst_n,
   input wire logic                      conversion_request_n,
   input wire logic                      comp_high,
   input wire logic                      serial_data,
   input wire logic                      serial_data_oe_n,
   input wire logic                      track_enable,
   input wire logic                      calib_active,
   input wire logic                      ref_change_ok,
   input wire logic [RESULT_WIDTH-1:0]   dac_code,
   input wire logic [RESULT_WIDTH-1:0]   result_code,
   input wire logic                      result_valid,
   input wire logic                      conv_start,
   input wire logic                      conv_busy,
   input wire logic [3:0]                conv_clock,
   input wire adc_seq_pkg::run_mode_type run_mode
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   chk_start_drive: assert property (conv_start |-> !serial_data_oe_n && conv_clock == 4'h1)
      else $error("driver not enabled at start");
   chk_lead_low: assert property (conv_clock inside {[4'h1:4'h4]} |-> !serial_data)
      else $error("data not low before msb");
   chk_conv_len: assert property (conv_start |-> ##13 (result_valid && conv_clock == 4'he))
      else $error("conversion length wrong");
   chk_hold_window: assert property (conv_clock inside {[4'h4:4'hd]} |-> !track_enable)
      else $error("tracking during conversion");
   chk_ref_window: assert property (conv_clock inside {[4'h4:4'hd]} |-> !ref_change_ok)
      else $error("reference change allowed too early");
   chk_idle_hiz: assert property (!conv_busy |-> serial_data_oe_n)
      else $error("driver on while idle");
   chk_chain_start: assert property (conv_clock == 4'he ##1 conv_busy |-> conv_start && !serial_data_oe_n)
      else $error("chained conversion not started");
   chk_count_step: assert property (conv_busy && conv_clock != 4'he |=> conv_clock == $past(conv_clock) + 4'h1)
      else $error("cycle counter skipped");
   chk_sar_first: assert property (conv_clock == 4'h4 |-> dac_code == 10'h200)
      else $error("first trial code wrong");
   chk_lsb_out: assert property (result_valid |-> serial_data == result_code[0] && !serial_data_oe_n)
      else $error("lsb differs from result");

   cov_start: cover property (conv_start);
   cov_chain: cover property (result_valid ##1 conv_start);
   cov_idle:  cover property (result_valid ##1 !conv_busy);
endmodule // adc_seq_checker

bind serial_adc_conversion_sequencer adc_seq_checker #(.RESULT_WIDTH(RESULT_WIDTH)) checker_i (
   .clk_sys(clk_sys), .arst_n(arst_n), .conversion_request_n(conversion_request_n),
   .comp_high(comp_high), .serial_data(serial_data), .serial_data_oe_n(serial_data_oe_n),
   .track_enable(track_enable), .calib_active(calib_active), .ref_change_ok(ref_change_ok),
   .dac_code(dac_code), .result_code(result_code), .result_valid(result_valid),
   .conv_start(conv_start), .conv_busy(conv_busy), .conv_clock(conv_clock), .run_mode(run_mode));

// ---- verification/analog_source_model.sv ----
// ****************************************************************
// ideal analog input with sample and hold and comparator
// ****************************************************************
module analog_source_model (
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   input  wire logic       track_enable,
   input  wire logic [9:0] dac_code,
   input  wire logic [9:0] level,
   output logic            comp_high
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [9:0] held_q;

   // follows the input only while tracking, so late changes are ignored
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         held_q <= 10'h000;
      end else if (track_enable) begin
         held_q <= level;
      end
   end

   // ideal comparator: straight binary code equals the level
   assign comp_high = (held_q >= dac_code);
endmodule // analog_source_model

// ---- verification/serial_adc_conversion_sequencer_tb_top.sv ----
module serial_adc_conversion_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic       clk_sys, arst_n, conversion_request_n, comp_high, serial_data, serial_data_oe_n;
   logic       track_enable, calib_active, ref_change_ok, result_valid, conv_start, conv_busy;
   logic [9:0] dac_code, result_code, level;
   logic [3:0] conv_clock;
   adc_seq_pkg::run_mode_type run_mode;
   int         n_fail, n_tests;

   serial_adc_conversion_sequencer serial_adc_conversion_sequencer_i (
      .clk_sys(clk_sys), .arst_n(arst_n), .conversion_request_n(conversion_request_n),
      .comp_high(comp_high), .serial_data(serial_data), .serial_data_oe_n(serial_data_oe_n),
      .track_enable(track_enable), .calib_active(calib_active), .ref_change_ok(ref_change_ok),
      .dac_code(dac_code), .result_code(result_code), .result_valid(result_valid),
      .conv_start(conv_start), .conv_busy(conv_busy), .conv_clock(conv_clock), .run_mode(run_mode));

   analog_source_model analog_source_model_i (
      .clk_sys(clk_sys), .arst_n(arst_n), .track_enable(track_enable),
      .dac_code(dac_code), .level(level), .comp_high(comp_high));

   // ****************************************************************
   // clock, kept running through every conversion
   // ****************************************************************
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic close_out;
      $display("tests %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // inputs change a fixed delay after the edge, outputs settled by then
   task automatic step;
      @(posedge clk_sys);
      #2;
   endtask

   task automatic wait_start;
      int i;
      i = 0;
      while (conv_start !== 1'b1 && i < 8) begin
         step;
         i++;
      end
      if (i == 8) begin
         n_fail++;
         close_out;
      end
   endtask

   // walks clocks 1..14 of one conversion, ends inside clock 14;
   // a nonzero low_at lowers the request again in that clock
   task automatic conv_body(input logic [9:0] code, input logic rel, input int low_at = 0);
      for (int c = 1; c <= 14; c++) begin
         check(serial_data_oe_n, 1'b0);
         check(calib_active, c <= 2);
         if (c <= 4) begin
            check(serial_data, 1'b0);
         end else begin
            check(serial_data, code[14-c]);
         end
         if (c == 4) begin
            check(track_enable, 1'b0);
         end
         if (c == 14) begin
            check(result_valid, 1'b1);
            check(result_code, code);
         end
         if (c == 1 && rel) begin
            conversion_request_n = 1'b1;
         end
         if (c == low_at) begin
            conversion_request_n = 1'b0;
         end
         if (c < 14) begin
            step;
         end
      end
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_single(input logic [9:0] code);
      level = code;
      conversion_request_n = 1'b0;
      wait_start;
      check(conv_clock, 4'h1);
      conv_body(code, 1'b1);
      step;
      check(run_mode, adc_seq_pkg::MODE_SINGLE_SHOT);
      repeat (6) begin
         check(serial_data_oe_n, 1'b1);
         check(conv_busy, 1'b0);
         step;
      end
      $display("single shot %h done", code);
   endtask

   task automatic t_free;
      level = 10'h2aa;
      conversion_request_n = 1'b0;
      wait_start;
      conv_body(10'h2aa, 1'b0);
      level = 10'h155; // new level picked up while tracking
      step;
      check(conv_start, 1'b1);
      check(serial_data_oe_n, 1'b0);
      check(run_mode, adc_seq_pkg::MODE_FREE_RUN);
      conv_body(10'h155, 1'b1);
      step;
      $display("free run done");
   endtask

   task automatic t_sync;
      level = 10'h0f0;
      conversion_request_n = 1'b0;
      wait_start;
      conv_body(10'h0f0, 1'b1);
      step;
      // idle clocks stretch the reference settling window
      repeat (5) begin
         check(serial_data_oe_n, 1'b1);
         check(ref_change_ok, 1'b1);
         step;
      end
      level = 10'h30f;
      conversion_request_n = 1'b0;
      wait_start;
      // released then lowered again before clock fourteen: chains
      conv_body(10'h30f, 1'b1, 10);
      step;
      check(conv_start, 1'b1);
      check(run_mode, adc_seq_pkg::MODE_SYNCHRONIZED);
      conv_body(10'h30f, 1'b1);
      step;
      check(serial_data_oe_n, 1'b1);
      $display("synchronized done");
   endtask

   initial begin
      n_fail = 0;
      n_tests = 0;
      arst_n = 1'b0;
      conversion_request_n = 1'b1;
      level = 10'h000;
      repeat (12) @(posedge clk_sys);
      #2;
      arst_n = 1'b1;
      step;
      check(serial_data_oe_n, adc_seq_pkg::OE_N_RESET);
      check(track_enable, adc_seq_pkg::TRACK_RESET);
      check(ref_change_ok, adc_seq_pkg::REFOK_RESET);
      check(calib_active, 1'b0);
      check(run_mode, adc_seq_pkg::MODE_NONE);
      t_single(10'h000);
      t_single(10'h3ff);
      t_single(10'h200);
      t_single(10'h1ff);
      t_free;
      t_sync;
      close_out;
   end
endmodule // serial_adc_conversion_sequencer_tb_top
